// ==== verilog/arsld_top.sv ====
// analog reference scaling, loss detection and loss reaction
//
// Behaviour
// - writing 1 to return code then pressing program enter exits the group
// - voltage reference is low-pass filtered, time constant default 10 ms
// - minimum voltage point, default 0.00 V, maps to minimum frequency 0.00 Hz
// - maximum voltage point, default 10.00 V, maps to maximum frequency 60.00 Hz
// - voltage scaling used only for voltage or combined frequency source
// - current reference is low-pass filtered, own time constant default 10 ms
// - minimum current point, default 4.00 mA, maps to minimum frequency 0.00 Hz
// - maximum current point, default 20.00 mA, maps to maximum frequency 60.00 Hz
// - loss criterion 0 performs no analog loss check
// - loss criterion 1 flags loss below half the minimum point
// - loss criterion 2 flags loss below the minimum point
// - analog loss checked only for voltage, current or combined source
// - voltage loss and current loss have distinct flags
// - option timeout, option communication and sub-board loss have own flags
// - reaction 0 keeps running after loss
// - reaction 1 cuts the output at once, motor coasts
// - reaction 2 requests deceleration to stop
// - loss must persist for the timeout before it is judged
// - reaction and timeout also govern command loss on keypad sources
// - multi-function inputs default to step-speed low, mid, high codes
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module arsld_top
    import arsld_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYC
)(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [DW-1:0] reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [DW-1:0] reg_rdata,
    input  wire logic [DW-1:0] voltage_ref_input,
    input  wire logic [DW-1:0] current_ref_input,
    input  wire logic [DW-1:0] keypad_freq,
    input  wire logic          cmd_freq_lost,
    input  wire logic          option_timeout_in,
    input  wire logic          option_comm_in,
    input  wire logic          subboard_loss_in,
    input  wire logic          program_enter_key,
    output logic      [DW-1:0] freq_ref_out,
    output logic               output_enable,
    output logic               coast_output_off,
    output logic               decel_stop,
    output logic               volt_loss_flag,
    output logic               curr_loss_flag,
    output logic               option_timeout_flag,
    output logic               option_comm_flag,
    output logic               subboard_loss_flag,
    output logic               ref_lost,
    output logic               group_exit,
    output logic      [DW-1:0] multi_input_a,
    output logic      [DW-1:0] multi_input_b,
    output logic      [DW-1:0] multi_input_c
);
    typedef struct packed {
        logic [NCFG-1:0][DW-1:0] cfg;
        logic [NST-1:0]          status;
        arsld_rx_t               rx;
        logic [DW-1:0]           ms_cnt;
        logic [23:0]             to_cnt;
        logic                    tick;
        logic [DW-1:0]           freq;
        logic [DW-1:0]           rdata;
        logic                    exit_p;
    } arsld_state_t;

    arsld_state_t  st_ff;
    arsld_state_t  nxt_st;
    arsld_bus_t    bus;
    arsld_curve_t  vcurve;
    arsld_curve_t  icurve;
    arsld_src_t    src;
    arsld_crit_t   crit;
    logic [1:0]    reac;
    logic [DW-1:0] vfilt;
    logic [DW-1:0] ifilt;
    logic [DW-1:0] vfreq;
    logic [DW-1:0] ifreq;
    logic [DW-1:0] vthr;
    logic [DW-1:0] ithr;
    logic          v_used;
    logic          i_used;
    logic          v_cond;
    logic          i_cond;
    logic          k_cond;
    logic          any_cond;
    logic [23:0]   to_ms;
    logic          to_hit;
    logic          judge;
    logic [NST-1:0] st_set;
    logic [NST-1:0] st_clr;
    logic [DW:0]   sum;
    logic [DW-1:0] rmux;

    assign bus    = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign src    = arsld_src_t'(st_ff.cfg[A_CTRL][CT_SRC_LSB +: 3]);
    assign crit   = arsld_crit_t'(st_ff.cfg[A_CTRL][CT_CRIT_LSB +: 2]);
    assign reac   = st_ff.cfg[A_CTRL][CT_REAC_LSB +: 2];
    assign vcurve = '{x1: st_ff.cfg[A_VX1], y1: st_ff.cfg[A_VY1],
                      x2: st_ff.cfg[A_VX2], y2: st_ff.cfg[A_VY2]};
    assign icurve = '{x1: st_ff.cfg[A_IX1], y1: st_ff.cfg[A_IY1],
                      x2: st_ff.cfg[A_IX2], y2: st_ff.cfg[A_IY2]};

    arsld_filter u_vflt (
        .clk    (clk),
        .rst    (rst),
        .tick   (st_ff.tick),
        .sample (voltage_ref_input),
        .tc_ms  (st_ff.cfg[A_VFILT]),
        .filt   (vfilt)
    );

    arsld_filter u_iflt (
        .clk    (clk),
        .rst    (rst),
        .tick   (st_ff.tick),
        .sample (current_ref_input),
        .tc_ms  (st_ff.cfg[A_IFILT]),
        .filt   (ifilt)
    );

    arsld_scale u_vscl (
        .clk   (clk),
        .rst   (rst),
        .x     (vfilt),
        .curve (vcurve),
        .freq  (vfreq)
    );

    arsld_scale u_iscl (
        .clk   (clk),
        .rst   (rst),
        .x     (ifilt),
        .curve (icurve),
        .freq  (ifreq)
    );

    // loss conditions
    always_comb begin
        v_used = (src == ARSLD_SRC_VOLT) || (src == ARSLD_SRC_COMB);
        i_used = (src == ARSLD_SRC_CURR) || (src == ARSLD_SRC_COMB);
        vthr   = vcurve.x1;
        ithr   = icurve.x1;
        if (crit == ARSLD_CRIT_HALF) begin
            vthr = vcurve.x1 >> 1;
            ithr = icurve.x1 >> 1;
        end
        v_cond = 1'b0;
        i_cond = 1'b0;
        if (crit == ARSLD_CRIT_HALF || crit == ARSLD_CRIT_BELOW) begin
            v_cond = v_used && (vfilt < vthr);
            i_cond = i_used && (ifilt < ithr);
        end
        k_cond   = cmd_freq_lost && ((src == ARSLD_SRC_KEY1) || (src == ARSLD_SRC_KEY2));
        any_cond = v_cond || i_cond || k_cond;
        to_ms    = 24'(st_ff.cfg[A_TOUT] * MS_PER_TO);
        to_hit   = any_cond && (st_ff.to_cnt >= to_ms);
        judge    = to_hit && !st_ff.status[ST_LOST];
    end

    // sticky status, set wins over write-one clear
    always_comb begin
        st_set              = '0;
        st_set[ST_VOLT]     = judge && v_cond;
        st_set[ST_CURR]     = judge && i_cond;
        st_set[ST_CMD]      = judge && k_cond;
        st_set[ST_LOST]     = judge;
        st_set[ST_OPTTO]    = option_timeout_in;
        st_set[ST_OPTCOM]   = option_comm_in;
        st_set[ST_SUB]      = subboard_loss_in;
        st_clr              = '0;
        if (bus.wr && bus.addr == A_STATUS) begin
            st_clr = bus.wdata[NST-1:0];
        end
    end

    // frequency source selection
    always_comb begin
        sum = {1'b0, vfreq} + {1'b0, ifreq};
        unique case (src)
            ARSLD_SRC_VOLT: rmux = vfreq;
            ARSLD_SRC_CURR: rmux = ifreq;
            ARSLD_SRC_COMB: rmux = sum[DW] ? FREQ_MAX : sum[DW-1:0];
            default:        rmux = keypad_freq;
        endcase
    end

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.exit_p = 1'b0;
        nxt_st.freq   = rmux;
        nxt_st.status = (st_ff.status & ~st_clr) | st_set;
        nxt_st.tick   = 1'b0;
        nxt_st.ms_cnt = st_ff.ms_cnt + 16'h0001;
        if (st_ff.ms_cnt >= DW'(MS_CYCLES - 1)) begin
            nxt_st.ms_cnt = '0;
            nxt_st.tick   = 1'b1;
        end
        if (!any_cond) begin
            nxt_st.to_cnt = '0;
        end else if (st_ff.tick && !to_hit) begin
            nxt_st.to_cnt = st_ff.to_cnt + 24'h000001;
        end
        if (bus.wr && bus.addr < A_STATUS) begin
            nxt_st.cfg[bus.addr[3:0]] = bus.wdata;
        end
        if (program_enter_key && st_ff.cfg[A_RET] == RET_EXIT) begin
            nxt_st.exit_p      = 1'b1;
            nxt_st.cfg[A_RET]  = '0;
        end
        unique case (st_ff.rx)
            ARSLD_RX_RUN: begin
                if (judge && reac == 2'h1) begin
                    nxt_st.rx = ARSLD_RX_COAST;
                end else if (judge && reac == 2'h2) begin
                    nxt_st.rx = ARSLD_RX_DECEL;
                end
            end
            ARSLD_RX_COAST, ARSLD_RX_DECEL: begin
                if (!nxt_st.status[ST_LOST]) begin
                    nxt_st.rx = ARSLD_RX_RUN;
                end
            end
            default: nxt_st.rx = ARSLD_RX_RUN;
        endcase
        nxt_st.rdata = '0;
        if (bus.rd) begin
            if (bus.addr < A_STATUS) begin
                nxt_st.rdata = st_ff.cfg[bus.addr[3:0]];
            end else if (bus.addr == A_STATUS) begin
                nxt_st.rdata = DW'(st_ff.status);
            end else if (bus.addr == A_FREQ) begin
                nxt_st.rdata = st_ff.freq;
            end else if (bus.addr == A_STATE) begin
                nxt_st.rdata = DW'(st_ff.rx);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff        <= '0;
            st_ff.cfg    <= CFG_RST;
            st_ff.rx     <= ARSLD_RX_RUN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata           = st_ff.rdata;
    assign freq_ref_out        = st_ff.freq;
    assign output_enable       = (st_ff.rx != ARSLD_RX_COAST);
    assign coast_output_off    = (st_ff.rx == ARSLD_RX_COAST);
    assign decel_stop          = (st_ff.rx == ARSLD_RX_DECEL);
    assign volt_loss_flag      = st_ff.status[ST_VOLT];
    assign curr_loss_flag      = st_ff.status[ST_CURR];
    assign option_timeout_flag = st_ff.status[ST_OPTTO];
    assign option_comm_flag    = st_ff.status[ST_OPTCOM];
    assign subboard_loss_flag  = st_ff.status[ST_SUB];
    assign ref_lost            = st_ff.status[ST_LOST];
    assign group_exit          = st_ff.exit_p;
    assign multi_input_a       = st_ff.cfg[A_MIA];
    assign multi_input_b       = st_ff.cfg[A_MIB];
    assign multi_input_c       = st_ff.cfg[A_MIC];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    group_exit_a: assert property (group_exit |-> $past(program_enter_key) && $past(st_ff.cfg[A_RET]) == RET_EXIT)
        else $error("group exit without return code and key");
    no_check_a: assert property ($rose(volt_loss_flag) |-> $past(crit) != ARSLD_CRIT_NONE)
        else $error("voltage loss raised with checking off");
    half_thr_a: assert property (crit == ARSLD_CRIT_HALF && src == ARSLD_SRC_VOLT && vfilt < (vcurve.x1 >> 1) |-> any_cond)
        else $error("half minimum loss not detected");
    src_gate_a: assert property (src == ARSLD_SRC_KEY1 || src == ARSLD_SRC_KEY2 |-> !v_cond && !i_cond)
        else $error("analog loss checked on keypad source");
    timeout_a: assert property ($rose(ref_lost) |-> $past(st_ff.to_cnt) >= $past(to_ms) && $past(any_cond))
        else $error("loss judged before timeout");
    coast_cut_a: assert property ($rose(ref_lost) && $past(reac) == 2'h1 |-> !output_enable ##1 !output_enable || !ref_lost)
        else $error("output not cut on loss");
    decel_req_a: assert property ($rose(ref_lost) && $past(reac) == 2'h2 |-> decel_stop && output_enable)
        else $error("no deceleration request on loss");
    keep_run_a: assert property ($rose(ref_lost) && $past(reac) == 2'h0 |-> output_enable && !decel_stop)
        else $error("output stopped with keep running reaction");
    opt_flag_a: assert property (option_timeout_in && option_comm_in |=> option_timeout_flag && option_comm_flag)
        else $error("option loss flags not raised");
    mi_dflt_a: assert property ($past(rst) && !reg_wr |-> multi_input_a == CFG_RST[A_MIA] && multi_input_b == CFG_RST[A_MIB] && multi_input_c == CFG_RST[A_MIC])
        else $error("multi input defaults wrong after reset");

endmodule : arsld_top

// ==== verilog/arsld_pkg.sv ====
// constants, types and register map of the analog reference scaling and loss block
package arsld_pkg;

    localparam int unsigned DW          = 16;
    localparam int unsigned AW          = 5;
    localparam int unsigned CLK_NS      = 25;
    localparam int unsigned MS_NS       = 1000000;
    localparam int unsigned MS_CYC      = MS_NS / CLK_NS;
    localparam logic [7:0]  MS_PER_TO   = 8'h64;

    // register indices
    localparam logic [AW-1:0] A_CTRL    = 5'h00;
    localparam logic [AW-1:0] A_VFILT   = 5'h01;
    localparam logic [AW-1:0] A_VX1     = 5'h02;
    localparam logic [AW-1:0] A_VY1     = 5'h03;
    localparam logic [AW-1:0] A_VX2     = 5'h04;
    localparam logic [AW-1:0] A_VY2     = 5'h05;
    localparam logic [AW-1:0] A_IFILT   = 5'h06;
    localparam logic [AW-1:0] A_IX1     = 5'h07;
    localparam logic [AW-1:0] A_IY1     = 5'h08;
    localparam logic [AW-1:0] A_IX2     = 5'h09;
    localparam logic [AW-1:0] A_IY2     = 5'h0a;
    localparam logic [AW-1:0] A_TOUT    = 5'h0b;
    localparam logic [AW-1:0] A_RET     = 5'h0c;
    localparam logic [AW-1:0] A_MIA     = 5'h0d;
    localparam logic [AW-1:0] A_MIB     = 5'h0e;
    localparam logic [AW-1:0] A_MIC     = 5'h0f;
    localparam int unsigned   NCFG      = 16;
    localparam logic [AW-1:0] A_STATUS  = 5'h10;
    localparam logic [AW-1:0] A_FREQ    = 5'h11;
    localparam logic [AW-1:0] A_STATE   = 5'h12;

    // control register fields
    localparam int unsigned CT_SRC_LSB  = 0;
    localparam int unsigned CT_CRIT_LSB = 4;
    localparam int unsigned CT_REAC_LSB = 8;

    // status bits
    localparam int unsigned ST_VOLT     = 0;
    localparam int unsigned ST_CURR     = 1;
    localparam int unsigned ST_OPTTO    = 2;
    localparam int unsigned ST_OPTCOM   = 3;
    localparam int unsigned ST_SUB      = 4;
    localparam int unsigned ST_CMD      = 5;
    localparam int unsigned ST_LOST     = 6;
    localparam int unsigned NST         = 7;

    localparam logic [DW-1:0] RET_EXIT  = 16'h0001;
    localparam logic [DW-1:0] FREQ_MAX  = 16'hffff;

    // reset values: voltage 10 mV units, current 10 uA units, frequency 0.01 Hz,
    // filter in ms, timeout in 0.1 s
    localparam logic [NCFG-1:0][DW-1:0] CFG_RST = {
        16'h0002, 16'h0001, 16'h0000, 16'h0000, 16'h000a,
        16'h1770, 16'h07d0, 16'h0000, 16'h0190, 16'h000a,
        16'h1770, 16'h03e8, 16'h0000, 16'h0000, 16'h000a,
        16'h0002
    };

    typedef enum logic [2:0] {
        ARSLD_SRC_KEY1 = 3'b000,
        ARSLD_SRC_KEY2 = 3'b001,
        ARSLD_SRC_VOLT = 3'b010,
        ARSLD_SRC_CURR = 3'b011,
        ARSLD_SRC_COMB = 3'b100
    } arsld_src_t;

    typedef enum logic [1:0] {
        ARSLD_CRIT_NONE  = 2'b00,
        ARSLD_CRIT_HALF  = 2'b01,
        ARSLD_CRIT_BELOW = 2'b10
    } arsld_crit_t;

    typedef enum logic [1:0] {
        ARSLD_RX_RUN   = 2'b00,
        ARSLD_RX_COAST = 2'b01,
        ARSLD_RX_DECEL = 2'b10
    } arsld_rx_t;

    typedef struct packed {
        logic [DW-1:0] x1;
        logic [DW-1:0] y1;
        logic [DW-1:0] x2;
        logic [DW-1:0] y2;
    } arsld_curve_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } arsld_bus_t;

endpackage : arsld_pkg

// ==== verilog/arsld_filter.sv ====
// first order low pass filter, time constant in ms
`timescale 1ns/10ps
module arsld_filter
    import arsld_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          tick,
    input  wire logic [DW-1:0] sample,
    input  wire logic [DW-1:0] tc_ms,
    output logic      [DW-1:0] filt
);
    typedef struct packed {
        logic [DW-1:0] y;
    } arsld_flt_t;

    arsld_flt_t    st_ff;
    arsld_flt_t    nxt_st;
    logic [3:0]    shift;
    logic signed [DW:0] diff;
    logic signed [DW:0] step;

    // shift of about log2 of the time constant
    always_comb begin
        shift = 4'h0;
        for (int i = 1; i < DW; i++) begin
            if (tc_ms >= (DW'(1) << i)) begin
                shift = 4'(i);
            end
        end
    end

    always_comb begin
        nxt_st = st_ff;
        diff   = $signed({1'b0, sample}) - $signed({1'b0, st_ff.y});
        step   = diff >>> shift;
        if (tick) begin
            nxt_st.y = 16'($signed({1'b0, st_ff.y}) + step);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign filt = st_ff.y;

endmodule : arsld_filter

// ==== verilog/arsld_scale.sv ====
// two point linear map with clamping at the end points
`timescale 1ns/10ps
module arsld_scale
    import arsld_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [DW-1:0] x,
    input  arsld_curve_t       curve,
    output logic      [DW-1:0] freq
);
    typedef struct packed {
        logic [DW-1:0] f;
    } arsld_scl_t;

    arsld_scl_t           st_ff;
    arsld_scl_t           nxt_st;
    logic signed [DW:0]   dx;
    logic signed [DW:0]   dy;
    logic signed [DW:0]   den;
    logic signed [2*DW+1:0] quo;

    always_comb begin
        nxt_st = st_ff;
        dx     = $signed({1'b0, x}) - $signed({1'b0, curve.x1});
        dy     = $signed({1'b0, curve.y2}) - $signed({1'b0, curve.y1});
        den    = $signed({1'b0, curve.x2}) - $signed({1'b0, curve.x1});
        quo    = '0;
        if (x <= curve.x1 || den <= 0) begin
            nxt_st.f = curve.y1;
        end else if (x >= curve.x2) begin
            nxt_st.f = curve.y2;
        end else begin
            quo      = (dx * dy) / den;
            nxt_st.f = 16'($signed({2'b00, curve.y1}) + quo);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign freq = st_ff.f;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    clamp_low_a: assert property (x <= curve.x1 ##1 $stable(curve) |-> freq == curve.y1)
        else $error("frequency not clamped to low end point");

endmodule : arsld_scale

// ==== bench/arsld_far_model.sv ====
// far side model: analog reference sources and motor output stage
`timescale 1ns/10ps
module arsld_far_model
    import arsld_pkg::*;
(
    input  wire logic          clk,
    input  wire logic [DW-1:0] freq_ref_out,
    input  wire logic          coast_output_off,
    input  wire logic          decel_stop,
    output logic      [DW-1:0] voltage_ref_input,
    output logic      [DW-1:0] current_ref_input,
    output logic      [DW-1:0] motor_speed
);
    initial begin
        voltage_ref_input = 16'h0000;
        current_ref_input = 16'h0190;
        motor_speed       = 16'h0000;
    end

    // new analog levels right after an edge
    task automatic set_ref(input logic [DW-1:0] v, input logic [DW-1:0] i);
        @(posedge clk);
        voltage_ref_input <= v;
        current_ref_input <= i;
    endtask : set_ref

    // motor: stops at once when coasting, ramps down on decel
    always @(posedge clk) begin
        if (coast_output_off) begin
            motor_speed <= 16'h0000;
        end else if (decel_stop && motor_speed != 16'h0000) begin
            motor_speed <= motor_speed - 16'h0001;
        end else if (!decel_stop) begin
            motor_speed <= freq_ref_out;
        end
    end
endmodule : arsld_far_model

// ==== bench/testbench.sv ====
// self-checking bench of the analog reference scaling and loss block
`timescale 1ns/10ps
module testbench;
    import arsld_pkg::*;
    localparam int unsigned MSC    = 4;
    localparam int unsigned TO_CYC = 100 * MSC;
    // entries: source, voltage, current, expected frequency
    localparam logic [63:0] SC [9] = '{
        64'h0002_0000_0190_0000, 64'h0002_00fa_0190_05dc, 64'h0002_03e8_0190_1770,
        64'h0002_04b0_0190_1770, 64'h0003_03e8_0190_0000, 64'h0003_0000_04b0_0bb8,
        64'h0003_0000_07d0_1770, 64'h0003_0000_0064_0000, 64'h0004_00fa_04b0_1194};
    logic clk, rst, reg_wr, reg_rd, cmd_freq_lost, option_timeout_in, option_comm_in;
    logic subboard_loss_in, program_enter_key, output_enable, coast_output_off, decel_stop;
    logic volt_loss_flag, curr_loss_flag, option_timeout_flag, option_comm_flag;
    logic subboard_loss_flag, ref_lost, group_exit, rd_q;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata, reg_rdata, voltage_ref_input, current_ref_input, keypad_freq;
    logic [DW-1:0] freq_ref_out, multi_input_a, multi_input_b, multi_input_c, motor_speed;
    logic [DW-1:0] exp_q [$];
    logic [31:0]   seed;
    int            failures, checked, n;

    arsld_top #(.MS_CYCLES(MSC)) i_arsld_top (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .voltage_ref_input, .current_ref_input, .keypad_freq,
        .cmd_freq_lost, .option_timeout_in, .option_comm_in, .subboard_loss_in,
        .program_enter_key, .freq_ref_out, .output_enable, .coast_output_off, .decel_stop,
        .volt_loss_flag, .curr_loss_flag, .option_timeout_flag, .option_comm_flag,
        .subboard_loss_flag, .ref_lost, .group_exit, .multi_input_a, .multi_input_b,
        .multi_input_c);
    arsld_far_model i_arsld_far_model (.clk, .freq_ref_out, .coast_output_off, .decel_stop,
        .voltage_ref_input, .current_ref_input, .motor_speed);

    always #12.5 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction : xs

    task automatic cmp(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic report_and_stop();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask : rd

    // read data stand in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_q) begin
            cmp(reg_rdata, exp_q.pop_front());
        end
        rd_q <= reg_rd;
    end

    // hold a loss condition past the timeout, check judgement and reaction
    task automatic loss(input logic [DW-1:0] ctrl, input logic [DW-1:0] v,
                        input logic [DW-1:0] i, input logic c,
                        input logic [DW-1:0] st, input logic [DW-1:0] state);
        wr(A_CTRL, ctrl);
        i_arsld_far_model.set_ref(v, i);
        cmd_freq_lost <= c;
        cyc(TO_CYC - 40);
        cmp(DW'(ref_lost), 16'h0000);
        cyc(80);
        rd(A_STATUS, st);
        rd(A_STATE, state);
        cmp(DW'(output_enable), DW'(state != 16'h0001));
        cmp(DW'(decel_stop), DW'(state == 16'h0002));
        cmp(DW'(coast_output_off), DW'(state == 16'h0001));
        i_arsld_far_model.set_ref(16'h03e8, 16'h04b0);
        cmd_freq_lost <= 1'b0;
        cyc(12);
        wr(A_STATUS, 16'h007f);
        cyc(3);
        cmp(DW'(ref_lost), 16'h0000);
    endtask : loss

    task automatic press(input int e);
        @(posedge clk);
        program_enter_key <= 1'b1;
        @(posedge clk);
        program_enter_key <= 1'b0;
        n = 0;
        for (int k = 0; k < 3; k++) begin
            #1;
            n += int'(group_exit);
            @(posedge clk);
        end
        cmp(DW'(n), DW'(e));
    endtask : press

    initial begin
        clk = 1'b0; rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; rd_q = 1'b0;
        reg_addr = '0; reg_wdata = '0; keypad_freq = '0; cmd_freq_lost = 1'b0;
        option_timeout_in = 1'b0; option_comm_in = 1'b0; subboard_loss_in = 1'b0;
        program_enter_key = 1'b0; seed = 32'h7c91f332; failures = 0; checked = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < NCFG; k++) rd(AW'(k), CFG_RST[k]);
        rd(5'h13, 16'h0000);
        cyc(1);
        cmp(multi_input_a, 16'h0000);
        cmp(multi_input_b, 16'h0001);
        cmp(multi_input_c, 16'h0002);
        i_arsld_far_model.set_ref(16'h03e8, 16'h0190);
        cyc(8);
        cmp(DW'(freq_ref_out == 16'h1770), 16'h0000);
        wr(A_VFILT, 16'h0001);
        wr(A_IFILT, 16'h0001);
        wr(A_TOUT, 16'h0001);
        for (int k = 0; k < 9; k++) begin
            wr(A_CTRL, SC[k][63:48]);
            i_arsld_far_model.set_ref(SC[k][47:32], SC[k][31:16]);
            cyc(12);
            rd(A_FREQ, SC[k][15:0]);
        end
        for (int k = 0; k < 4; k++) begin
            wr(A_CTRL, DW'(k[0]));
            seed = xs(seed);
            keypad_freq <= seed[15:0];
            cyc(4);
            rd(A_FREQ, seed[15:0]);
        end
        wr(A_VX1, 16'h00c8);
        loss(16'h0013, 16'h03e8, 16'h0096, 1'b0, 16'h0042, 16'h0000);
        loss(16'h0123, 16'h03e8, 16'h012c, 1'b0, 16'h0042, 16'h0001);
        loss(16'h0213, 16'h03e8, 16'h012c, 1'b0, 16'h0000, 16'h0000);
        loss(16'h0222, 16'h0064, 16'h04b0, 1'b0, 16'h0041, 16'h0002);
        loss(16'h0203, 16'h03e8, 16'h0000, 1'b0, 16'h0000, 16'h0000);
        loss(16'h0220, 16'h0000, 16'h0000, 1'b0, 16'h0000, 16'h0000);
        loss(16'h0100, 16'h03e8, 16'h04b0, 1'b1, 16'h0060, 16'h0001);
        @(posedge clk);
        option_timeout_in <= 1'b1;
        option_comm_in    <= 1'b1;
        subboard_loss_in  <= 1'b1;
        @(posedge clk);
        option_timeout_in <= 1'b0;
        option_comm_in    <= 1'b0;
        subboard_loss_in  <= 1'b0;
        rd(A_STATUS, 16'h001c);
        wr(A_STATUS, 16'h001c);
        rd(A_STATUS, 16'h0000);
        press(0);
        wr(A_RET, RET_EXIT);
        press(1);
        rd(A_RET, 16'h0000);
        cyc(3);
        report_and_stop();
    end

    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule : testbench
